// ### verilog/tcb_pkg.sv
// constants for the transmit command and buffer path
// assumes a 32-bit apb register port and a 100 mhz ref_clk
package tcb_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DATA   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SPACE  = 8'h08;
    localparam logic [7:0] OFS_FLAGS  = 8'h0c;
    localparam logic [7:0] OFS_CFG    = 8'h10;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // flag and config bit positions
    localparam int FLG_ERR  = 0;
    localparam int FLG_LOAD = 1;
    localparam int CFG_PAD  = 0;
    localparam int CFG_IRQ  = 1;
    localparam int CFG_THR_LO = 8;
    localparam int CFG_THR_HI = 12;
    // command word a fields
    localparam int A_IOC     = 31;
    localparam int A_ALN_HI  = 25;
    localparam int A_ALN_LO  = 24;
    localparam int A_OFS_HI  = 20;
    localparam int A_OFS_LO  = 16;
    localparam int A_FIRST   = 13;
    localparam int A_LAST    = 12;
    localparam int A_SIZE_HI = 10;
    // command word b fields
    localparam int B_TAG_HI = 31;
    localparam int B_TAG_LO = 16;
    localparam int B_LEN_HI = 10;
    // end alignment codes and byte masks
    localparam logic [1:0]  ALN_16  = 2'h1;
    localparam logic [1:0]  ALN_32  = 2'h2;
    localparam logic [11:0] MASK_4  = 12'h003;
    localparam logic [11:0] MASK_16 = 12'h00f;
    localparam logic [11:0] MASK_32 = 12'h01f;
    localparam logic [11:0] WORD_BYTES = 12'h004;
    // fifo shapes
    localparam int DF_AW    = 8;
    localparam int DF_DEPTH = 256;
    localparam int ENTRY_W  = 54;
    localparam int SF_AW    = 4;
    localparam int SF_DEPTH = 16;
    typedef enum logic [1:0] {ST_CMDA, ST_CMDB, ST_DATA} tcb_parse_type;
endpackage

// ### verilog/tcb_sts_if.sv
// status word queue connection between the path and its status fifo
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface tcb_sts_if;
    logic                      push;
    logic [31:0]               pushWord;
    logic                      pop;
    logic [31:0]               head;
    logic [tcb_pkg::SF_AW:0]   level;
    logic                      full;
    logic                      empty;
    modport store (input push, input pushWord, input pop,
                   output head, output level, output full, output empty);
    modport user  (output push, output pushWord, output pop,
                   input head, input level, input full, input empty);
endinterface

// ### verilog/tcb_status_fifo.sv
// transmit status word fifo
// assumes active-low reset from the parent, asserted asynchronously and released synchronously
`timescale 1ns/1ps
module tcb_status_fifo (
    input wire logic   ref_clk,
    input wire logic   rst_n,
    tcb_sts_if.store   sts
);
    logic [31:0]              mem [tcb_pkg::SF_DEPTH];
    logic [tcb_pkg::SF_AW-1:0] wrPtr_q;
    logic [tcb_pkg::SF_AW-1:0] rdPtr_q;
    logic [tcb_pkg::SF_AW:0]   level_q;
    wire doPush = sts.push & ~sts.full;
    wire doPop  = sts.pop & ~sts.empty;

    // flags from the level count, head from the read pointer
    assign sts.full  = level_q == (tcb_pkg::SF_AW+1)'(tcb_pkg::SF_DEPTH);
    assign sts.empty = level_q == '0;
    assign sts.level = level_q;
    assign sts.head  = mem[rdPtr_q];

    // storage, no reset on the array
    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            mem[wrPtr_q] <= sts.pushWord;
        end
    end

    // pointers and level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            level_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + tcb_pkg::SF_AW'(doPush);
            rdPtr_q <= rdPtr_q + tcb_pkg::SF_AW'(doPop);
            level_q <= level_q + (tcb_pkg::SF_AW+1)'(doPush) - (tcb_pkg::SF_AW+1)'(doPop);
        end
    end

    chk_push_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doPush && !doPop |=> level_q == $past(level_q) + 1)
        else $error("status push did not raise the level");
endmodule // tcb_status_fifo

// ### verilog/tcb_tx_cmd_path.sv
// transmit command parser, data fifo and status posting
// assumes an apb master on ref_clk and a mac drain on the same clock
//
// Behaviour
// - each buffer opens with a two-word command header steering its handling
// - the command tag is copied into that packet's status word
// - differing tags among one packet's buffers set the error flag
// - delivered byte count not equal to commanded length sets the error flag
// - payload starts at the offset byte; earlier bytes are dropped
// - every following buffer starts at its own offset byte
// - when enabled, trailing padding words are accepted and dropped
// - trailing data up to the selected end alignment is dropped
// - a status word is posted on each mac completion, good or failed, unless the status fifo is full
// - optional interrupt when status count reaches a programmed level
// - writing into a full data fifo sets the error flag
// - command words are 32 bits, exactly one a and one b per buffer
// - differing command b words within a packet set the error flag
// - interrupt-on-completion bit raises the buffer loaded flag
// - only retained payload words occupy and count in the data fifo
// - end alignment code 00 4, 01 16, 10 32 bytes, 11 reserved
// - start offset field bits 20:16 selects byte 0 to 31
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module tcb_tx_cmd_path (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txValid,
    input  wire logic        txReady,
    output logic [31:0]      txData,
    output logic [1:0]       txLane,
    output logic [2:0]       txCount,
    output logic             txLast,
    input  wire logic        macDone,
    input  wire logic        macFailed,
    output logic             statusThresholdIrq,
    output logic             bufferLoadedOut
);
    logic [1:0] rstPipe_q;
    wire        rst_n = rstPipe_q[1];

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end

    tcb_sts_if sts ();
    tcb_status_fifo u_status (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sts     (sts)
    );

    // apb decode, answer on the second access cycle
    logic ack_q;
    wire  apbAccess = psel & penable;
    wire  apbDone   = apbAccess & ack_q;
    wire  selData   = paddr == tcb_pkg::OFS_DATA;
    wire  selStatus = paddr == tcb_pkg::OFS_STATUS;
    wire  selSpace  = paddr == tcb_pkg::OFS_SPACE;
    wire  selFlags  = paddr == tcb_pkg::OFS_FLAGS;
    wire  selCfg    = paddr == tcb_pkg::OFS_CFG;
    wire  mapped    = selData | selStatus | selSpace | selFlags | selCfg;
    wire  hostWord  = apbDone & pwrite & selData;
    wire  flagWr    = apbDone & pwrite & selFlags;
    wire  cfgWr     = apbDone & pwrite & selCfg;
    assign pready   = apbDone;
    assign pslverr  = apbDone & ~mapped;

    // parser state and captured command words
    tcb_pkg::tcb_parse_type state_q;
    logic [31:0] cmdA_q;
    logic [31:0] cmdB_q;
    logic [31:0] savedB_q;
    logic [9:0]  wordCnt_q;
    logic [11:0] pktBytes_q;
    logic [31:0] cfg_q;
    logic        err_q;
    logic        loaded_q;
    logic        irq_q;

    // command a fields
    wire        aIoc   = cmdA_q[tcb_pkg::A_IOC];
    wire [1:0]  aAlign = cmdA_q[tcb_pkg::A_ALN_HI:tcb_pkg::A_ALN_LO];
    wire [4:0]  aOfs   = cmdA_q[tcb_pkg::A_OFS_HI:tcb_pkg::A_OFS_LO];
    wire        aFirst = cmdA_q[tcb_pkg::A_FIRST];
    wire        aLast  = cmdA_q[tcb_pkg::A_LAST];
    wire [10:0] aSize  = cmdA_q[tcb_pkg::A_SIZE_HI:0];
    wire        padEn  = cfg_q[tcb_pkg::CFG_PAD];
    wire [tcb_pkg::SF_AW:0] thr = cfg_q[tcb_pkg::CFG_THR_HI:tcb_pkg::CFG_THR_LO];

    // byte window of the buffer and its padded end
    wire [11:0] startB    = {7'h00, aOfs};
    wire [11:0] endB      = startB + {1'b0, aSize};
    wire [11:0] alignMask = !padEn ? tcb_pkg::MASK_4 :
                            (aAlign == tcb_pkg::ALN_16) ? tcb_pkg::MASK_16 :
                            (aAlign == tcb_pkg::ALN_32) ? tcb_pkg::MASK_32 :
                            tcb_pkg::MASK_4;
    wire [11:0] roundEnd   = (endB + alignMask) & ~alignMask;
    wire [9:0]  totalWords = roundEnd[11:2];
    wire        lastOfBuf  = wordCnt_q == totalWords - 10'h001;

    // bytes of the current host word that fall inside the payload
    wire [11:0] pos      = {wordCnt_q, 2'h0};
    wire [11:0] posEnd   = pos + tcb_pkg::WORD_BYTES;
    wire [11:0] lo       = (pos > startB) ? pos : startB;
    wire [11:0] hi       = (posEnd < endB) ? posEnd : endB;
    wire        keepWord = hi > lo;
    wire [11:0] laneFull = lo - pos;
    wire [11:0] cntFull  = hi - lo;
    wire        lastByte = aLast & (hi == endB);

    // buffer and packet events
    wire inCmdB    = state_q == tcb_pkg::ST_CMDB;
    wire inData    = state_q == tcb_pkg::ST_DATA;
    wire [31:0] bWord = inCmdB ? pwdata : cmdB_q;
    wire bufEnd    = hostWord & ((inData & lastOfBuf) | (inCmdB & totalWords == 10'h000));
    wire [11:0] pktBase  = aFirst ? 12'h000 : pktBytes_q;
    wire [11:0] pktTotal = pktBase + {1'b0, aSize};
    wire [31:0] refB     = aFirst ? bWord : savedB_q;
    wire tagDiff   = hostWord & inCmdB & ~aFirst &
                     (pwdata[tcb_pkg::B_TAG_HI:tcb_pkg::B_TAG_LO] !=
                      savedB_q[tcb_pkg::B_TAG_HI:tcb_pkg::B_TAG_LO]);
    wire bDiff     = hostWord & inCmdB & ~aFirst & (pwdata != savedB_q);
    wire lenDiff   = bufEnd & aLast & (pktTotal != {1'b0, refB[tcb_pkg::B_LEN_HI:0]});

    // data fifo storage
    logic [tcb_pkg::ENTRY_W-1:0] dmem [tcb_pkg::DF_DEPTH];
    logic [tcb_pkg::DF_AW-1:0]   dWr_q;
    logic [tcb_pkg::DF_AW-1:0]   dRd_q;
    logic [tcb_pkg::DF_AW:0]     dLevel_q;
    logic [tcb_pkg::ENTRY_W-1:0] out_q;
    logic                        outValid_q;
    logic [15:0]                 doneTag_q;
    wire dFull    = dLevel_q == (tcb_pkg::DF_AW+1)'(tcb_pkg::DF_DEPTH);
    wire dEmpty   = dLevel_q == '0;
    wire wantPush = hostWord & inData & keepWord;
    wire dPush    = wantPush & ~dFull;
    wire overfill = wantPush & dFull;
    wire outLoad  = ~dEmpty & (~outValid_q | txReady);
    wire outTake  = outValid_q & txReady;
    wire [tcb_pkg::ENTRY_W-1:0] newEntry = {cmdB_q[tcb_pkg::B_TAG_HI:tcb_pkg::B_TAG_LO],
                                            lastByte, cntFull[2:0], laneFull[1:0], pwdata};
    wire [tcb_pkg::DF_AW:0] space = (tcb_pkg::DF_AW+1)'(tcb_pkg::DF_DEPTH) - dLevel_q;
    wire errSet = overfill | tagDiff | bDiff | lenDiff;

    // drain stage outputs
    assign txValid = outValid_q;
    assign txData  = out_q[31:0];
    assign txLane  = out_q[33:32];
    assign txCount = out_q[36:34];
    assign txLast  = out_q[37];

    // status word posting on mac completion
    assign sts.push     = macDone;
    assign sts.pushWord = {doneTag_q, 14'h0000, err_q, macFailed};
    assign sts.pop      = apbDone & ~pwrite & selStatus;
    assign statusThresholdIrq = irq_q;
    assign bufferLoadedOut    = loaded_q;

    // read mux
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        if (selStatus) begin
            rdMux = sts.empty ? 32'h0000_0000 : sts.head;
        end else if (selSpace) begin
            rdMux = {11'h000, sts.level, 7'h00, space};
        end else if (selFlags) begin
            rdMux = {30'h0, loaded_q, err_q};
        end else if (selCfg) begin
            rdMux = cfg_q;
        end
    end

    // apb answer timing and read data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q  <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            ack_q <= apbAccess & ~ack_q;
            if (apbAccess & ~ack_q & ~pwrite) begin
                prdata <= rdMux;
            end
        end
    end

    // header then payload sequencing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= tcb_pkg::ST_CMDA;
            wordCnt_q <= 10'h000;
        end else if (hostWord) begin
            case (state_q)
                tcb_pkg::ST_CMDA: begin
                    state_q <= tcb_pkg::ST_CMDB;
                end
                tcb_pkg::ST_CMDB: begin
                    wordCnt_q <= 10'h000;
                    state_q   <= bufEnd ? tcb_pkg::ST_CMDA : tcb_pkg::ST_DATA;
                end
                tcb_pkg::ST_DATA: begin
                    wordCnt_q <= wordCnt_q + 10'h001;
                    if (lastOfBuf) begin
                        state_q <= tcb_pkg::ST_CMDA;
                    end
                end
                default: begin
                    state_q <= tcb_pkg::ST_CMDA;
                end
            endcase
        end
    end

    // command capture and packet byte accounting
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdA_q     <= 32'h0000_0000;
            cmdB_q     <= 32'h0000_0000;
            savedB_q   <= 32'h0000_0000;
            pktBytes_q <= 12'h000;
        end else begin
            if (hostWord & state_q == tcb_pkg::ST_CMDA) begin
                cmdA_q <= pwdata;
            end
            if (hostWord & inCmdB) begin
                cmdB_q <= pwdata;
                if (aFirst) begin
                    savedB_q <= pwdata;
                end
            end
            if (bufEnd) begin
                pktBytes_q <= pktTotal;
            end
        end
    end

    // flags, set wins over software clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q    <= 1'b0;
            loaded_q <= 1'b0;
            cfg_q    <= tcb_pkg::CFG_RESET;
            irq_q    <= 1'b0;
        end else begin
            err_q    <= errSet | (err_q & ~(flagWr & pwdata[tcb_pkg::FLG_ERR]));
            loaded_q <= (bufEnd & aIoc) |
                        (loaded_q & ~(flagWr & pwdata[tcb_pkg::FLG_LOAD]));
            if (cfgWr) begin
                cfg_q <= pwdata;
            end
            irq_q <= cfg_q[tcb_pkg::CFG_IRQ] & (thr != '0) & (sts.level >= thr);
        end
    end

    // data fifo array
    always_ff @(posedge ref_clk) begin
        if (dPush) begin
            dmem[dWr_q] <= newEntry;
        end
        if (outLoad) begin
            out_q <= dmem[dRd_q];
        end
    end

    // data fifo pointers, drain stage and tag of the departing packet
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dWr_q      <= '0;
            dRd_q      <= '0;
            dLevel_q   <= '0;
            outValid_q <= 1'b0;
            doneTag_q  <= 16'h0000;
        end else begin
            dWr_q    <= dWr_q + tcb_pkg::DF_AW'(dPush);
            dRd_q    <= dRd_q + tcb_pkg::DF_AW'(outLoad);
            dLevel_q <= dLevel_q + (tcb_pkg::DF_AW+1)'(dPush)
                        - (tcb_pkg::DF_AW+1)'(outLoad);
            outValid_q <= outLoad | (outValid_q & ~txReady);
            if (outTake & txLast) begin
                doneTag_q <= out_q[tcb_pkg::ENTRY_W-1:38];
            end
        end
    end

    chk_error_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        err_q && !flagWr |=> err_q)
        else $error("error flag dropped without a clear");
    chk_overfill_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
        overfill |=> err_q && dLevel_q == $past(dLevel_q) - (tcb_pkg::DF_AW+1)'($past(outLoad)))
        else $error("overfill not flagged or word stored");
    chk_tag_mismatch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tagDiff |=> err_q)
        else $error("tag mismatch not flagged");
    chk_cmdb_mismatch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bDiff |=> err_q ##1 err_q || $past(flagWr))
        else $error("command b mismatch not flagged");
    chk_length_check: assert property (@(posedge ref_clk) disable iff (!rst_n)
        lenDiff |=> err_q)
        else $error("length mismatch not flagged");
    chk_loaded_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bufEnd && aIoc |=> loaded_q && state_q == tcb_pkg::ST_CMDA)
        else $error("buffer loaded flag missing");
    chk_offset_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hostWord && inData && posEnd <= startB |=> dLevel_q <= $past(dLevel_q))
        else $error("word before start offset was stored");
    chk_header_seq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hostWord && state_q == tcb_pkg::ST_CMDA |=> state_q == tcb_pkg::ST_CMDB)
        else $error("command a not followed by command b slot");
    chk_thresh_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_q[tcb_pkg::CFG_IRQ] && thr != '0 && sts.level >= thr && !sts.pop && !cfgWr
        |=> ##1 statusThresholdIrq)
        else $error("status threshold interrupt missing");
endmodule // tcb_tx_cmd_path

// ### dv/tcb_mac_model.sv
// mac side model: drains payload words and posts completions
// assumes the path's drain handshake on ref_clk
`timescale 1ns/1ps
module tcb_mac_model (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic txValid,
    input  wire logic txLast,
    input  wire logic stall,
    input  wire logic failNext,
    output logic      txReady,
    output logic      macDone,
    output logic      macFailed
);
    integer     seed = 32'haa21;
    logic [1:0] delayQ;
    // random ready, completion pulse three cycles after the last word
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            txReady   <= 1'b0;
            macDone   <= 1'b0;
            macFailed <= 1'b0;
            delayQ    <= 2'h0;
        end else begin
            txReady   <= !stall && (($random(seed) & 3) != 0);
            macDone   <= (delayQ == 2'h1);
            macFailed <= (delayQ == 2'h1) && failNext;
            if (txValid && txReady && txLast)
                delayQ <= 2'h3;
            else if (delayQ != 2'h0)
                delayQ <= delayQ - 2'h1;
        end
    end
endmodule // tcb_mac_model

// ### dv/testbench.sv
// self-checking bench for the transmit command path
// assumes the mac model drains words and pulses completion
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [31:0] d;
        logic [1:0]  ln;
        logic [2:0]  cnt;
        logic        lst;
    } tcb_drain_type;
    logic          refClk = 1'b0, arstN = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]    paddr  = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, txData, msk, cb;
    logic          pready, pslverr, txValid, txReady, txLast, macDone, macFailed;
    logic          statusThresholdIrq, bufferLoadedOut;
    logic [1:0]    txLane;
    logic [2:0]    txCount;
    logic          stall = 1'b0, failNext = 1'b0, padOn = 1'b0;
    logic [15:0]   tag, tg1;
    int            failCount = 0, cmpCount = 0;
    integer        seed = 32'haa21;
    tcb_drain_type expQ[$], e;
    logic [32:0]   rdQ[$], r;

    tcb_tx_cmd_path dut (.ref_clk(refClk), .arst_n(arstN), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .txValid, .txReady, .txData, .txLane, .txCount,
        .txLast, .macDone, .macFailed, .statusThresholdIrq, .bufferLoadedOut);
    tcb_mac_model mac (.ref_clk(refClk), .arst_n(arstN), .txValid, .txLast, .stall,
        .failNext, .txReady, .macDone, .macFailed);

    initial forever #5 refClk = ~refClk;

    task automatic check(input string nm, input logic [63:0] ex, input logic [63:0] got);
        cmpCount++;
        if (got !== ex) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic summarize;
        if (failCount == 0 && cmpCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic doReset;
        arstN <= 1'b0;
        repeat (2) @(posedge refClk);
        arstN <= 1'b1;
        repeat (3) @(posedge refClk);
    endtask

    // one apb transfer held until pready is seen high, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge refClk);
        penable <= 1'b1;
        do begin
            @(posedge refClk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge refClk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic er);
        rdQ.push_back({er, ex});
        apb(1'b0, a, 32'h0);
    endtask

    // command pair, then payload words up to the end alignment
    task automatic sendBuf(input logic ioc, input logic [1:0] aln, input int ofs, input int sz,
                           input logic fst, input logic lst, input logic [31:0] cbw,
                           input logic chk);
        int          al, nw, lo, hi;
        logic [31:0] wd, ca;
        al = !padOn ? 4 : aln == tcb_pkg::ALN_16 ? 16 : aln == tcb_pkg::ALN_32 ? 32 : 4;
        nw = (ofs + sz + al - 1) / al * al / 4;
        ca = {ioc, 5'h0, aln, 3'h0, ofs[4:0], 2'h0, fst, lst, 1'b0, sz[10:0]};
        apb(1'b1, tcb_pkg::OFS_DATA, ca);
        apb(1'b1, tcb_pkg::OFS_DATA, cbw);
        for (int w = 0; w < nw; w++) begin
            wd = $random(seed);
            lo = (4*w > ofs) ? 4*w : ofs;
            hi = (4*w + 3 < ofs + sz - 1) ? 4*w + 3 : ofs + sz - 1;
            if (chk && lo <= hi)
                expQ.push_back('{wd, 2'(lo - 4*w), 3'(hi - lo + 1), lst && hi == ofs + sz - 1});
            apb(1'b1, tcb_pkg::OFS_DATA, wd);
        end
    endtask

    // wait for the drain to go quiet with every noted word consumed
    task automatic waitIdle;
        int quiet;
        quiet = 0;
        for (int n = 0; n < 4000 && quiet < 16; n++) begin
            @(posedge refClk);
            quiet = (txValid || expQ.size() > 0) ? 0 : quiet + 1;
        end
        check("drain idle", 1, quiet >= 16);
    endtask

    // drained words against the oldest note, valid lanes only
    always @(posedge refClk) begin
        if (txValid && txReady && expQ.size() > 0) begin
            e = expQ.pop_front();
            for (int i = 0; i < 4; i++)
                msk[8*i +: 8] = (i >= e.ln && i < e.ln + e.cnt) ? 8'hff : 8'h00;
            e.d = e.d & msk;
            check("drain", e, {txData & msk, txLane, txCount, txLast});
        end
    end

    // read data and error response against the oldest note
    always @(posedge refClk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0) begin
            r = rdQ.pop_front();
            check("read", r, {pslverr, prdata});
        end
    end

    initial begin
        doReset;
        rd(tcb_pkg::OFS_SPACE, 32'h0000_0100, 1'b0);
        rd(tcb_pkg::OFS_CFG, tcb_pkg::CFG_RESET, 1'b0);
        rd(tcb_pkg::OFS_FLAGS, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        // single buffer with the completion flag
        tag = $random(seed);
        sendBuf(1'b1, 2'h0, 0, 8, 1'b1, 1'b1, {tag, 5'h0, 11'd8}, 1'b1);
        waitIdle;
        check("loaded", 1, bufferLoadedOut);
        rd(tcb_pkg::OFS_FLAGS, 32'h2, 1'b0);
        rd(tcb_pkg::OFS_STATUS, {tag, 16'h0}, 1'b0);
        apb(1'b1, tcb_pkg::OFS_FLAGS, 32'h2);
        rd(tcb_pkg::OFS_FLAGS, 32'h0, 1'b0);
        // two buffers with their own offsets; alignment ignored without padding
        tag = $random(seed);
        sendBuf(1'b0, 2'h0, 5, 6, 1'b1, 1'b0, {tag, 5'h0, 11'd9}, 1'b1);
        sendBuf(1'b0, 2'h2, 30, 3, 1'b0, 1'b1, {tag, 5'h0, 11'd9}, 1'b1);
        waitIdle;
        rd(tcb_pkg::OFS_STATUS, {tag, 16'h0}, 1'b0);
        // padding stripped while the drain stalls, then the status threshold
        padOn = 1'b1;
        apb(1'b1, tcb_pkg::OFS_CFG, 32'h0000_0203);
        stall <= 1'b1;
        tg1 = $random(seed);
        sendBuf(1'b0, tcb_pkg::ALN_32, 4, 5, 1'b1, 1'b1, {tg1, 5'h0, 11'd5}, 1'b1);
        rd(tcb_pkg::OFS_SPACE, 32'h0000_00ff, 1'b0);
        stall <= 1'b0;
        waitIdle;
        tag = $random(seed);
        failNext <= 1'b1;
        sendBuf(1'b0, tcb_pkg::ALN_16, 0, 20, 1'b1, 1'b1, {tag, 5'h0, 11'd20}, 1'b1);
        waitIdle;
        failNext <= 1'b0;
        check("irq", 1, statusThresholdIrq);
        rd(tcb_pkg::OFS_STATUS, {tg1, 16'h0}, 1'b0);
        rd(tcb_pkg::OFS_STATUS, {tag, 16'h1}, 1'b0);
        repeat (3) @(posedge refClk);
        check("irq", 0, statusThresholdIrq);
        padOn = 1'b0;
        apb(1'b1, tcb_pkg::OFS_CFG, 32'h0);
        // packets that mismatch: tag and command b across two buffers, length in one buffer
        for (int k = 0; k < 3; k++) begin
            tag = $random(seed);
            cb  = (k == 0) ? {~tag, 16'h8} : {tag, 5'h1, 11'd8};
            if (k == 2)
                sendBuf(1'b0, 2'h0, 0, 4, 1'b1, 1'b1, {tag, 16'h8}, 1'b0);
            else begin
                sendBuf(1'b0, 2'h0, 0, 4, 1'b1, 1'b0, {tag, 16'h8}, 1'b0);
                sendBuf(1'b0, 2'h0, 1, 4, 1'b0, 1'b1, cb, 1'b0);
            end
            waitIdle;
            rd(tcb_pkg::OFS_FLAGS, 32'h1, 1'b0);
            repeat (20) @(posedge refClk);
            rd(tcb_pkg::OFS_FLAGS, 32'h1, 1'b0);
            apb(1'b1, tcb_pkg::OFS_FLAGS, 32'h1);
            rd(tcb_pkg::OFS_FLAGS, 32'h0, 1'b0);
        end
        // overfill with the drain stalled, then a reset in mid-run
        stall <= 1'b1;
        sendBuf(1'b0, 2'h0, 0, 1032, 1'b1, 1'b1, {tag, 5'h0, 11'd1032}, 1'b0);
        rd(tcb_pkg::OFS_FLAGS, 32'h1, 1'b0);
        stall <= 1'b0;
        waitIdle;
        doReset;
        rd(tcb_pkg::OFS_FLAGS, 32'h0, 1'b0);
        rd(tcb_pkg::OFS_SPACE, 32'h0000_0100, 1'b0);
        summarize;
    end

    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge refClk);
        check("timeout", 0, 1);
        summarize;
    end
endmodule // testbench
